/* File: hdl/pct_counter_timebase.sv */
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
// Contract
// - 16-bit counter seen as two bytes
// - Low read snapshots high byte for next read
// - Reads never disturb counting
// - Codes 000/001/101 select divided clocks, 100 the undivided system clock
// - 010 timer0 overflow, 011 falling input, 11x none
// - External oscillator tick synchronised to clock
// - Wrap from maximum sets overflow flag
// - Interrupt only while enable bit set
// - Overflow flag cleared only by software
// - Idle control zero keeps counting in idle
// - Six modules each with routable line
// - Watchdog mode after reset restricts access
module pct_counter_timebase
   import pct_pkg::*;
#(
   parameter int NUM_MODULES = 6
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata_q,
   // Event sources
   input wire logic ext_count_input,
   input wire logic timer0_overflow,
   input wire logic ext_osc_clk,
   input wire logic cpu_idle,
   // Interrupt
   output logic irq_q,
   // Module lines
   output logic [NUM_MODULES-1:0] module_io_line_q,
   output logic [NUM_MODULES-1:0] module_io_oe_q
);

   logic [1:0] rst_pipe_q;
   logic rst_n;
   logic [15:0] count_q;
   logic [7:0] snapshot_q;
   logic [3:0] pre_q;
   logic eci_prev_q;
   logic idle_suspend_ctrl_q;
   logic watchdog_mode_q;
   logic [2:0] timebase_select_q;
   logic count_overflow_flag_q;
   logic overflow_irq_enable_q;
   logic [NUM_MODULES-1:0] io_enable_q;
   logic [NUM_MODULES-1:0] io_level_q;
   logic ext_tick;
   logic tick12;
   logic tick4;
   logic eci_fall;
   logic src_tick;
   logic tick;
   logic cnt_lo_wr;
   logic cnt_hi_wr;
   logic cnt_wr;
   logic mode_wr;
   logic ovf_set;

   // ****************************************************************
   // Reset release
   // ****************************************************************
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rst_pipe_q <= 2'h0;
      else
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
   end

   assign rst_n = rst_pipe_q[1];

   function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
      wr_hit = reg_wr && (reg_addr == a);
   endfunction : wr_hit

   // Counter writes are locked out while watchdog mode is on; mode writes still reach the watchdog bit
   assign cnt_lo_wr = wr_hit(ADDR_COUNT_LOW) && !watchdog_mode_q;
   assign cnt_hi_wr = wr_hit(ADDR_COUNT_HIGH) && !watchdog_mode_q;
   assign cnt_wr = cnt_lo_wr || cnt_hi_wr;
   assign mode_wr = wr_hit(ADDR_MODE);

   // ****************************************************************
   // Timebase sources
   // ****************************************************************
   pct_ext_sync u_ext_sync (
      .clk(clk),
      .rst_n(rst_n),
      .ext_osc_clk(ext_osc_clk),
      .ext_tick_q(ext_tick)
   );

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pre_q <= 4'h0;
      else if (pre_q == DIV12_LAST)
         pre_q <= 4'h0;
      else
         pre_q <= pre_q + DIV12_STEP;
   end

   assign tick12 = (pre_q == DIV12_LAST);
   assign tick4 = (pre_q[1:0] == DIV4_LAST);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         eci_prev_q <= 1'b0;
      else
         eci_prev_q <= ext_count_input;
   end

   assign eci_fall = eci_prev_q && !ext_count_input;

   always_comb
   begin
      case (timebase_select_q)
         SEL_DIV12: src_tick = tick12;
         SEL_DIV4: src_tick = tick4;
         SEL_TIMER0: src_tick = timer0_overflow;
         SEL_ECI: src_tick = eci_fall;
         SEL_SYSCLK: src_tick = 1'b1;
         SEL_EXTOSC: src_tick = ext_tick;
         default: src_tick = 1'b0;
      endcase
   end

   // Idle only stops the count when the idle control bit asks for it
   assign tick = src_tick && !(cpu_idle && idle_suspend_ctrl_q);

   // ****************************************************************
   // Counter
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         count_q <= COUNT_RST;
      else if (cnt_lo_wr)
         count_q[7:0] <= reg_wdata;
      else if (cnt_hi_wr)
         count_q[15:8] <= reg_wdata;
      else if (tick)
         count_q <= count_q + COUNT_STEP;
   end

   assign ovf_set = tick && !cnt_wr && (count_q == COUNT_MAX);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         snapshot_q <= 8'h00;
      else if (reg_rd && (reg_addr == ADDR_COUNT_LOW))
         snapshot_q <= count_q[15:8];
   end

   // ****************************************************************
   // Mode, status and mask registers
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         watchdog_mode_q <= RST_WATCHDOG;
         idle_suspend_ctrl_q <= 1'b0;
         timebase_select_q <= RST_SEL;
      end
      else if (mode_wr)
      begin
         watchdog_mode_q <= reg_wdata[MODE_WDT_BIT];
         if (!watchdog_mode_q)
         begin
            idle_suspend_ctrl_q <= reg_wdata[MODE_IDLE_BIT];
            timebase_select_q <= reg_wdata[MODE_SEL_HI:MODE_SEL_LO];
         end
      end
   end

   // Set wins over a simultaneous write-one clear
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         count_overflow_flag_q <= 1'b0;
      else if (ovf_set)
         count_overflow_flag_q <= 1'b1;
      else if (wr_hit(ADDR_STATUS) && reg_wdata[STATUS_OVF_BIT])
         count_overflow_flag_q <= 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         overflow_irq_enable_q <= 1'b0;
      else if (wr_hit(ADDR_MASK))
         overflow_irq_enable_q <= reg_wdata[STATUS_OVF_BIT];
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_q <= 1'b0;
      else
         irq_q <= count_overflow_flag_q && overflow_irq_enable_q;
   end

   // ****************************************************************
   // Module lines
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         io_enable_q <= '0;
         io_level_q <= '0;
      end
      else
      begin
         if (wr_hit(ADDR_IO_ENABLE))
            io_enable_q <= reg_wdata[NUM_MODULES-1:0];
         if (wr_hit(ADDR_IO_LEVEL))
            io_level_q <= reg_wdata[NUM_MODULES-1:0];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_MODULES; gi++)
      begin : g_line
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               module_io_line_q[gi] <= 1'b0;
               module_io_oe_q[gi] <= 1'b0;
            end
            else
            begin
               module_io_line_q[gi] <= io_enable_q[gi] && io_level_q[gi];
               module_io_oe_q[gi] <= io_enable_q[gi];
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Read port
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata_q <= 8'h00;
      else if (!reg_rd)
         reg_rdata_q <= 8'h00;
      else
      begin
         case (reg_addr)
            ADDR_COUNT_LOW: reg_rdata_q <= count_q[7:0];
            ADDR_COUNT_HIGH: reg_rdata_q <= snapshot_q;
            ADDR_MODE: reg_rdata_q <= {idle_suspend_ctrl_q, watchdog_mode_q, 2'h0, timebase_select_q, 1'b0};
            ADDR_STATUS: reg_rdata_q <= {7'h00, count_overflow_flag_q};
            ADDR_MASK: reg_rdata_q <= {7'h00, overflow_irq_enable_q};
            ADDR_IO_ENABLE: reg_rdata_q <= 8'(io_enable_q);
            ADDR_IO_LEVEL: reg_rdata_q <= 8'(io_level_q);
            default: reg_rdata_q <= 8'h00;
         endcase
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence seq_low_read;
      reg_rd && (reg_addr == ADDR_COUNT_LOW);
   endsequence

   sequence seq_high_read;
      reg_rd && (reg_addr == ADDR_COUNT_HIGH);
   endsequence

   AST_INCREMENT: assert property (
      tick && !cnt_wr |=> count_q == $past(count_q) + COUNT_STEP)
      else $error("Counter did not advance by one on a tick");

   AST_WRAP_FLAG: assert property (
      tick && !cnt_wr && count_q == COUNT_MAX |=> count_q == COUNT_RST && count_overflow_flag_q)
      else $error("Wrap did not clear counter and set flag");

   AST_SNAPSHOT: assert property (
      seq_low_read ##1 seq_high_read |=> reg_rdata_q == $past(count_q[15:8], 2))
      else $error("High read did not return snapshot");

   AST_READ_NO_DISTURB: assert property (
      reg_rd && !cnt_wr && !tick |=> count_q == $past(count_q))
      else $error("Read altered the counter");

   AST_DIV12_PERIOD: assert property (
      tick12 |=> !tick12 [*8] ##1 !tick12 [*3] ##1 tick12)
      else $error("Divide by 12 period wrong");

   AST_DIV4_PERIOD: assert property (
      tick4 |=> !tick4 [*3] ##1 tick4)
      else $error("Divide by 4 period wrong");

   AST_ECI_FALL: assert property (
      timebase_select_q == SEL_ECI && $fell(ext_count_input) && !cpu_idle |-> tick)
      else $error("Falling external input not counted");

   AST_RESERVED: assert property (
      timebase_select_q[2:1] == 2'h3 |-> !tick)
      else $error("Reserved timebase produced a tick");

   AST_EXTOSC: assert property (
      timebase_select_q == SEL_EXTOSC && !cpu_idle |-> tick == ext_tick)
      else $error("External oscillator tick not used");

   AST_IRQ_GATE: assert property (
      count_overflow_flag_q && overflow_irq_enable_q |=> irq_q)
      else $error("Enabled overflow did not raise interrupt");

   AST_IRQ_MASKED: assert property (
      !overflow_irq_enable_q |=> !irq_q)
      else $error("Interrupt raised while disabled");

   AST_FLAG_STICKY: assert property (
      count_overflow_flag_q && !(reg_wr && reg_addr == ADDR_STATUS && reg_wdata[STATUS_OVF_BIT]) |=> count_overflow_flag_q)
      else $error("Overflow flag cleared without software");

   AST_IDLE_RUN: assert property (
      cpu_idle && !idle_suspend_ctrl_q && timebase_select_q == SEL_SYSCLK && !cnt_wr
      |=> count_q == $past(count_q) + COUNT_STEP)
      else $error("Counter stopped in idle with control clear");

   AST_IDLE_HOLD: assert property (
      cpu_idle && idle_suspend_ctrl_q && !cnt_wr |=> $stable(count_q))
      else $error("Counter advanced while suspended in idle");

   AST_WDT_LOCK: assert property (
      watchdog_mode_q && mode_wr |=> $stable(timebase_select_q) && $stable(idle_suspend_ctrl_q))
      else $error("Mode changed while watchdog mode on");

   AST_LINE_ROUTE: assert property (
      ##1 module_io_oe_q == $past(io_enable_q))
      else $error("Module line enable not routed");

endmodule : pct_counter_timebase

/* File: hdl/pct_ext_sync.sv */
`timescale 1ns/1ps
// Brings the external oscillator into the system clock domain and divides it by 8
module pct_ext_sync
   import pct_pkg::*;
(
   // System side
   input wire logic clk,
   input wire logic rst_n,
   // Oscillator
   input wire logic ext_osc_clk,
   // Tick
   output logic ext_tick_q
);

   logic sync1_q;
   logic sync2_q;
   logic prev_q;
   logic [2:0] div_q;
   logic rise;

   // ****************************************************************
   // Two-flop synchroniser and edge detect
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         sync1_q <= ext_osc_clk;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   assign rise = sync2_q & ~prev_q;

   // ****************************************************************
   // Divide by 8, one system clock pulse per eight rising oscillator edges
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_q <= 3'h0;
         ext_tick_q <= 1'b0;
      end
      else
      begin
         ext_tick_q <= rise && (div_q == EXT_DIV_LAST);
         if (rise)
            div_q <= div_q + EXT_DIV_STEP;
      end
   end

endmodule : pct_ext_sync

/* File: hdl/pct_pkg.sv */
package pct_pkg;

   // ****************************************************************
   // Register map: byte index on the plain register port
   // ****************************************************************
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam logic [2:0] ADDR_COUNT_LOW = 3'h0;
   localparam logic [2:0] ADDR_COUNT_HIGH = 3'h1;
   localparam logic [2:0] ADDR_MODE = 3'h2;
   localparam logic [2:0] ADDR_STATUS = 3'h3;
   localparam logic [2:0] ADDR_MASK = 3'h4;
   localparam logic [2:0] ADDR_IO_ENABLE = 3'h5;
   localparam logic [2:0] ADDR_IO_LEVEL = 3'h6;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int MODE_IDLE_BIT = 7;
   localparam int MODE_WDT_BIT = 6;
   localparam int MODE_SEL_HI = 3;
   localparam int MODE_SEL_LO = 1;
   localparam int STATUS_OVF_BIT = 0;
   localparam logic RST_WATCHDOG = 1'h1;
   localparam logic [2:0] RST_SEL = 3'h0;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] COUNT_STEP = 16'h0001;

   // ****************************************************************
   // Timebase codes
   // ****************************************************************
   localparam logic [2:0] SEL_DIV12 = 3'h0;
   localparam logic [2:0] SEL_DIV4 = 3'h1;
   localparam logic [2:0] SEL_TIMER0 = 3'h2;
   localparam logic [2:0] SEL_ECI = 3'h3;
   localparam logic [2:0] SEL_SYSCLK = 3'h4;
   localparam logic [2:0] SEL_EXTOSC = 3'h5;

   // ****************************************************************
   // Prescaler constants
   // ****************************************************************
   localparam logic [3:0] DIV12_LAST = 4'hb;
   localparam logic [3:0] DIV12_STEP = 4'h1;
   localparam logic [1:0] DIV4_LAST = 2'h3;
   localparam logic [2:0] EXT_DIV_LAST = 3'h7;
   localparam logic [2:0] EXT_DIV_STEP = 3'h1;

endpackage : pct_pkg

/* File: tb/pct_counter_timebase_tb.sv */
`timescale 1ns/1ps
module pct_counter_timebase_tb import pct_pkg::*;;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic cpu_idle = 1'b0;
   logic [7:0] reg_rdata_q, b;
   logic ext_count_input, timer0_overflow, ext_osc_clk, irq_q;
   logic [5:0] io_line, io_oe;
   logic [15:0] w;
   int mismatches = 0;
   int cmp_count = 0;
   logic [2:0] codes[8] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h2, 3'h3, 3'h6, 3'h7};
   int lens[8] = '{120, 40, 10, 400, 80, 40, 40, 40};
   logic [15:0] lows[8] = '{16'h9, 16'h9, 16'hc, 16'h9, 16'h9, 16'h9, 16'h0, 16'h0};
   logic [15:0] highs[8] = '{16'hb, 16'hb, 16'hc, 16'hb, 16'hb, 16'hb, 16'h0, 16'h0};

   always #4 clk = ~clk;

   pct_counter_timebase dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .ext_count_input(ext_count_input),
      .timer0_overflow(timer0_overflow), .ext_osc_clk(ext_osc_clk), .cpu_idle(cpu_idle),
      .irq_q(irq_q), .module_io_line_q(io_line), .module_io_oe_q(io_oe));

   pct_event_src src (.clk(clk), .ext_count_input(ext_count_input),
      .timer0_overflow(timer0_overflow), .ext_osc_clk(ext_osc_clk));

   // ****************************************
   // Register port access
   // ****************************************
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata_q;
   endtask : rd

   task automatic rd16(output logic [15:0] v);
      logic [7:0] lo, hi;
      rd(ADDR_COUNT_LOW, lo);
      rd(ADDR_COUNT_HIGH, hi);
      v = {hi, lo};
   endtask : rd16

   task automatic setcnt(input logic [15:0] v);
      wr(ADDR_COUNT_LOW, v[7:0]);
      wr(ADDR_COUNT_HIGH, v[15:8]);
   endtask : setcnt

   task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
      cmp_count++;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
         mismatches++;
         $display("[ERR] %0t got %h want %h..%h", $time, got, lo, hi);
      end
   endtask : chk

   task automatic wait_chk(input logic [15:0] got, input logic [15:0] e);
      chk(got, e, e);
   endtask : wait_chk

   task automatic give_verdict;
      if (mismatches == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   initial
   begin
      #100000;
      mismatches++;
      give_verdict();
   end

   // ****************************************
   // Test sequence
   // ****************************************
   initial
   begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      rd(ADDR_MODE, b);
      wait_chk(b, 8'h40);
      rd(ADDR_STATUS, b);
      wait_chk(b, 8'h00);
      rd(ADDR_MASK, b);
      wait_chk(b, 8'h00);
      // Locked mode write only clears the watchdog bit
      wr(ADDR_MODE, 8'h0c);
      rd(ADDR_MODE, b);
      wait_chk(b, 8'h00);
      wr(ADDR_MODE, 8'h0c);
      rd(ADDR_MODE, b);
      wait_chk(b, 8'h0c);
      setcnt(16'h1234);
      rd16(w);
      wait_chk(w, 16'h1234);
      wr(ADDR_MODE, 8'h4c);
      setcnt(16'h5678);
      rd16(w);
      wait_chk(w, 16'h1234);
      wr(ADDR_MODE, 8'h0c);
      // Every timebase code, counted over a window
      foreach (codes[i])
      begin
         setcnt(16'h0000);
         wr(ADDR_MODE, {4'h0, codes[i], 1'b0});
         repeat (lens[i]) @(posedge clk);
         wr(ADDR_MODE, 8'h0c);
         rd16(w);
         chk(w, lows[i], highs[i]);
      end
      // Wrap, flag, interrupt enable and software clear
      setcnt(16'hffff);
      wr(ADDR_MODE, 8'h08);
      wr(ADDR_MODE, 8'h0c);
      rd16(w);
      wait_chk(w, 16'h0001);
      rd(ADDR_STATUS, b);
      wait_chk(b, 8'h01);
      wait_chk(irq_q, 1'b0);
      wr(ADDR_MASK, 8'h01);
      repeat (20) @(posedge clk);
      #1;
      wait_chk(irq_q, 1'b1);
      rd(ADDR_STATUS, b);
      wait_chk(b, 8'h01);
      wr(ADDR_MASK, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      wait_chk(irq_q, 1'b0);
      wr(ADDR_MASK, 8'h01);
      wr(ADDR_STATUS, 8'h01);
      rd(ADDR_STATUS, b);
      wait_chk(b, 8'h00);
      wait_chk(irq_q, 1'b0);
      // Snapshot holds while the counter runs on
      setcnt(16'h00f0);
      rd(ADDR_COUNT_LOW, b);
      wait_chk(b, 8'hf0);
      wr(ADDR_MODE, 8'h08);
      repeat (100) @(posedge clk);
      rd(ADDR_COUNT_HIGH, b);
      wr(ADDR_MODE, 8'h0c);
      wait_chk(b, 8'h00);
      rd16(w);
      chk(w, 16'h0158, 16'h0158);
      // Idle handling
      setcnt(16'h0000);
      cpu_idle <= 1'b1;
      wr(ADDR_MODE, 8'h88);
      repeat (20) @(posedge clk);
      wr(ADDR_MODE, 8'h0c);
      rd16(w);
      wait_chk(w, 16'h0000);
      wr(ADDR_MODE, 8'h08);
      repeat (10) @(posedge clk);
      wr(ADDR_MODE, 8'h0c);
      rd16(w);
      chk(w, 16'h000c, 16'h000c);
      cpu_idle <= 1'b0;
      // Module lines and an unmapped index
      wr(ADDR_IO_ENABLE, 8'h3f);
      wr(ADDR_IO_LEVEL, 8'h2a);
      repeat (2) @(posedge clk);
      #1;
      wait_chk(io_line, 6'h2a);
      wait_chk(io_oe, 6'h3f);
      rd(3'h7, b);
      wait_chk(b, 8'h00);
      give_verdict();
   end
endmodule : pct_counter_timebase_tb

/* File: tb/pct_event_src.sv */
`timescale 1ns/1ps
// Far-side event sources, all free running so unselected ones must be ignored
module pct_event_src
(
   // Clock
   input wire logic clk,
   // Events
   output logic ext_count_input,
   output logic timer0_overflow,
   output logic ext_osc_clk
);
   logic [2:0] ph_q = 3'h0;

   // Oscillator unrelated in phase to the system clock
   initial
   begin
      ext_osc_clk = 1'b0;
      #3;
      forever #20 ext_osc_clk = ~ext_osc_clk;
   end

   always @(posedge clk)
   begin
      ph_q <= ph_q + 3'h1;
   end

   // Two cycles high, two low: the fastest rate the input may toggle
   assign ext_count_input = ~ph_q[1];
   assign timer0_overflow = (ph_q == 3'h7);
endmodule : pct_event_src
